/* rtl/iex_pkg.sv */
// Constants, opcodes and register map of the instruction execute datapath
// Functional notes
// - Sixteen carry/zero predicates; an instruction with a false predicate does not execute.
// - decrement_branch_nonzero decrements and branches only if the result is nonzero.
// - test_branch_zero/test_branch_nonzero branch on zero/nonzero value, never modifying it.
// - Call stores next address and jumps; jump_and_link stores any return; return jumps.
// - Effect bits force or suppress result write and enable carry and zero updates.
// - Byte, word and long hub reads load a register; writes store its low unit.
// - Absolute value, negated_magnitude and two's-complement negation of a 32-bit operand.
// - Conditional negate passes operand or its two's-complement negation chosen by C, !C, Z or !Z.
// - Unsigned and signed minimum and maximum limits clamp destination against source.
// - Extended add, subtract and compare include incoming carry for multi-word chains.
// - Signed sums add or subtract source, sign chosen by C, !C, Z or !Z.
// - compare_conditional_subtract subtracts only when source is not above destination.
// - Test computes bitwise AND for flags only, never writing the destination.
// - Field moves replace only source, destination or opcode-plus-write-effect bits (31:23) of destination.
// - Bit merges set masked destination bits to C, !C, Z or !Z.
// - Carry rotates shift by a count, filling vacated bits with carry.
// - mirror_low_bits reverses the low bits and zero-extends to 32 bits.
// - Logical shifts, rotations and sign-replicating arithmetic right shift by a count.
// - No-operation changes nothing and takes exactly four clock cycles.
// - system_tick_counter and launch_argument are read-only to the core.
// - port_input_sample reflects the 32 pins of port A.
// - Writable port_direction and port_output_latch set direction and level per pin.
// - Word decodes as opcode, effect bits, condition, destination and source fields.
package iex_pkg;
  // Instruction field positions
  localparam int FLD_OP_LSB = 26;
  localparam int FLD_ZW = 25;
  localparam int FLD_CW = 24;
  localparam int FLD_RW = 23;
  localparam int FLD_IMM = 22;
  localparam int FLD_CON_LSB = 18;
  localparam int FLD_DST_LSB = 9;
  localparam int FLD_SRC_LSB = 0;
  // Special core register addresses
  localparam logic [8:0] ADR_LAUNCH_ARG = 9'h1F0;
  localparam logic [8:0] ADR_TICK = 9'h1F1;
  localparam logic [8:0] ADR_PORT_IN = 9'h1F2;
  localparam logic [8:0] ADR_PORT_OUT = 9'h1F4;
  localparam logic [8:0] ADR_PORT_DIR = 9'h1F6;
  // APB byte offsets
  localparam logic [11:0] APB_CTRL = 12'h000;
  localparam logic [11:0] APB_STATUS = 12'h004;
  localparam logic [11:0] APB_LAUNCH = 12'h008;
  localparam logic [11:0] APB_RAM_ADDR = 12'h00C;
  localparam logic [11:0] APB_RAM_DATA = 12'h010;
  // Hub transfer sizes
  localparam logic [1:0] HSZ_BYTE = 2'h0;
  localparam logic [1:0] HSZ_WORD = 2'h1;
  localparam logic [1:0] HSZ_LONG = 2'h2;
  localparam logic [8:0] PC_START = 9'h000;
  // Opcodes
  localparam logic [5:0] OP_RDBYTE = 6'h00, OP_RDWORD = 6'h01, OP_HUB_READ_WORD32 = 6'h02;
  localparam logic [5:0] OP_ROR = 6'h08, OP_ROL = 6'h09, OP_SHR = 6'h0A, OP_SHL = 6'h0B;
  localparam logic [5:0] OP_RCR = 6'h0C, OP_RCL = 6'h0D, OP_SAR = 6'h0E, OP_REV = 6'h0F;
  localparam logic [5:0] OP_SIGNED_FLOOR = 6'h10, OP_SIGNED_CEILING = 6'h11, OP_MIN = 6'h12, OP_MAX = 6'h13;
  localparam logic [5:0] OP_SET_SOURCE_FIELD = 6'h14, OP_SET_DEST_FIELD = 6'h15, OP_SET_OPCODE_FIELD = 6'h16, OP_JUMP_AND_LINK = 6'h17;
  localparam logic [5:0] OP_AND = 6'h18, OP_ANDN = 6'h19, OP_OR = 6'h1A, OP_XOR = 6'h1B;
  localparam logic [5:0] OP_CARRY_BIT_MERGE = 6'h1C, OP_MUXNC = 6'h1D, OP_MUXZ = 6'h1E, OP_MUXNZ = 6'h1F;
  localparam logic [5:0] OP_ADD = 6'h20, OP_SUB = 6'h21, OP_ADDABS = 6'h22, OP_SUBABS = 6'h23;
  localparam logic [5:0] OP_CARRY_SIGNED_SUM = 6'h24, OP_SUMNC = 6'h25, OP_SUMZ = 6'h26, OP_SUMNZ = 6'h27;
  localparam logic [5:0] OP_MOV = 6'h28, OP_NEG = 6'h29, OP_ABS = 6'h2A, OP_NEGATED_MAGNITUDE = 6'h2B;
  localparam logic [5:0] OP_CARRY_CONDITIONAL_NEGATE = 6'h2C, OP_NEGNC = 6'h2D, OP_NEGZ = 6'h2E, OP_NEGNZ = 6'h2F;
  localparam logic [5:0] OP_CMPS = 6'h30, OP_CMPSX = 6'h31, OP_ADD_WITH_CARRY_IN = 6'h32, OP_SUBX = 6'h33;
  localparam logic [5:0] OP_ADDS = 6'h34, OP_SUBS = 6'h35, OP_ADDSX = 6'h36, OP_SUBSX = 6'h37;
  localparam logic [5:0] OP_COMPARE_CONDITIONAL_SUBTRACT = 6'h38, OP_DECREMENT_BRANCH_NONZERO = 6'h39, OP_TEST_BRANCH_NONZERO = 6'h3A, OP_TJZ = 6'h3B;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FETCH = 3'b001,
    ST_SRC = 3'b010,
    ST_DST = 3'b011,
    ST_EXEC = 3'b100,
    ST_HUB = 3'b101
  } iex_state_t;
endpackage

/* rtl/iex_core.sv */
// Execution core: sequencer, ALU, core register file, hub port and APB slave
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module iex_core
  import iex_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic hub_req,
  output logic hub_we,
  output logic [1:0] hub_size,
  output logic [15:0] hub_addr,
  output logic [31:0] hub_wdata,
  input wire logic hub_ack,
  input wire logic [31:0] hub_rdata,
  input wire logic [31:0] port_in,
  output logic [31:0] port_out,
  output logic [31:0] port_dir
);

  // ****************************************
  // State and storage
  // ****************************************
  typedef struct packed {
    iex_state_t st;
    logic [8:0] pc;
    logic [31:0] ir;
    logic [31:0] sval;
    logic [31:0] dval;
    logic c;
    logic z;
    logic [31:0] outl;
    logic [31:0] dirl;
    logic [31:0] launch;
    logic [31:0] tick;
    logic run;
    logic [8:0] ram_addr;
    logic hreq;
    logic hwe;
    logic [1:0] hsize;
    logic [15:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] rdata;
  } iex_regs_t;

  iex_regs_t r;
  iex_regs_t next_r;
  logic [31:0] ram [512];
  logic ram_we;
  logic [8:0] ram_wa;
  logic [31:0] ram_wd;
  logic [5:0] op;
  logic [8:0] dfield;
  logic [8:0] sfield;
  logic cond_ok;
  logic [31:0] alu_res;
  logic alu_c;
  logic alu_z;
  logic do_write;
  logic do_jump;
  logic [8:0] jump_to;
  logic apb_setup;
  logic apb_wr;
  logic addr_ok;

  // Register read with special addresses mapped onto live state
  function automatic logic [31:0] core_read(input logic [8:0] a, input iex_regs_t s,
                                            input logic [31:0] pins, input logic [31:0] mem);
    case (a)
      ADR_LAUNCH_ARG: core_read = s.launch;
      ADR_TICK: core_read = s.tick;
      ADR_PORT_IN: core_read = pins;
      ADR_PORT_OUT: core_read = s.outl;
      ADR_PORT_DIR: core_read = s.dirl;
      default: core_read = mem;
    endcase
  endfunction

  // Add or subtract with carry in; returns {signed overflow, carry or borrow, sum}
  function automatic logic [33:0] addsub(input logic [31:0] a, input logic [31:0] b,
                                         input logic sub, input logic cin);
    logic [32:0] t;
    logic ovf;
    t = sub ? ({1'b0, a} - {1'b0, b} - {32'h0, cin}) : ({1'b0, a} + {1'b0, b} + {32'h0, cin});
    ovf = sub ? ((a[31] != b[31]) && (t[31] != a[31])) : ((a[31] == b[31]) && (t[31] != a[31]));
    addsub = {ovf, t};
  endfunction

  assign op = r.ir[FLD_OP_LSB +: 6];
  assign dfield = r.ir[FLD_DST_LSB +: 9];
  assign sfield = r.ir[FLD_SRC_LSB +: 9];
  // Predicate table indexed by current carry and zero
  assign cond_ok = r.ir[FLD_CON_LSB + {r.c, r.z}];

  // ****************************************
  // Arithmetic and logic unit
  // ****************************************
  // Flags default to zero-result and carry unchanged; arithmetic and logic cases refine them
  always_comb begin
    logic [33:0] as;
    logic [31:0] d;
    logic [31:0] s;
    logic [31:0] rv;
    logic [4:0] n;
    logic sel;
    as = 34'h0;
    d = r.dval;
    s = r.sval;
    rv = 32'h0;
    n = s[4:0];
    sel = 1'b0;
    alu_res = d;
    alu_c = r.c;
    alu_z = 1'b0;
    case (op)
      OP_ROR: alu_res = (d >> n) | (d << (6'd32 - {1'b0, n}));
      OP_ROL: alu_res = (d << n) | (d >> (6'd32 - {1'b0, n}));
      OP_SHR: alu_res = d >> n;
      OP_SHL: alu_res = d << n;
      OP_SAR: alu_res = $signed(d) >>> n;
      OP_RCL: alu_res = (d << n) | (r.c ? ~(32'hFFFFFFFF << n) : 32'h0);
      OP_RCR: alu_res = (d >> n) | (r.c ? ~(32'hFFFFFFFF >> n) : 32'h0);
      OP_REV: begin
        for (int i = 0; i < 32; i++) begin
          rv[i] = d[31 - i];
        end
        alu_res = rv >> n;
      end
      OP_SIGNED_FLOOR: alu_res = ($signed(d) < $signed(s)) ? s : d;
      OP_SIGNED_CEILING: alu_res = ($signed(d) > $signed(s)) ? s : d;
      OP_MIN: alu_res = (d < s) ? s : d;
      OP_MAX: alu_res = (d > s) ? s : d;
      OP_SET_SOURCE_FIELD: alu_res = {d[31:9], s[8:0]};
      OP_SET_DEST_FIELD: alu_res = {d[31:18], s[8:0], d[8:0]};
      OP_SET_OPCODE_FIELD: alu_res = {s[8:0], d[22:0]};
      OP_JUMP_AND_LINK: alu_res = {d[31:9], r.pc + 9'h001};
      OP_AND: alu_res = d & s;
      OP_ANDN: alu_res = d & ~s;
      OP_OR: alu_res = d | s;
      OP_XOR: alu_res = d ^ s;
      OP_CARRY_BIT_MERGE, OP_MUXNC, OP_MUXZ, OP_MUXNZ: begin
        sel = op[1] ? r.z : r.c;
        sel = sel ^ op[0];
        alu_res = (d & ~s) | (sel ? s : 32'h0);
      end
      OP_MOV: alu_res = s;
      OP_NEG: alu_res = -s;
      OP_ABS: alu_res = s[31] ? -s : s;
      OP_NEGATED_MAGNITUDE: alu_res = s[31] ? s : -s;
      OP_CARRY_CONDITIONAL_NEGATE, OP_NEGNC, OP_NEGZ, OP_NEGNZ: begin
        sel = op[1] ? r.z : r.c;
        sel = sel ^ op[0];
        alu_res = sel ? -s : s;
      end
      OP_ADD, OP_SUB, OP_ADD_WITH_CARRY_IN, OP_SUBX, OP_ADDS, OP_SUBS, OP_ADDSX, OP_SUBSX: begin
        // Odd codes subtract; extended forms chain the carry in
        as = addsub(d, s, op[0], (op == OP_ADD_WITH_CARRY_IN || op == OP_SUBX || op == OP_ADDSX
                                  || op == OP_SUBSX) ? r.c : 1'b0);
        alu_res = as[31:0];
        alu_c = (op[4] && op[2]) ? as[33] : as[32];
      end
      OP_ADDABS, OP_SUBABS: begin
        as = addsub(d, s[31] ? -s : s, op[0], 1'b0);
        alu_res = as[31:0];
        alu_c = as[32];
      end
      OP_CARRY_SIGNED_SUM, OP_SUMNC, OP_SUMZ, OP_SUMNZ: begin
        sel = op[1] ? r.z : r.c;
        sel = sel ^ op[0];
        as = addsub(d, s, sel, 1'b0);
        alu_res = as[31:0];
        alu_c = as[33];
      end
      OP_CMPS, OP_CMPSX: begin
        as = addsub(d, s, 1'b1, (op == OP_CMPSX) ? r.c : 1'b0);
        alu_res = as[31:0];
        alu_c = as[31] ^ as[33];
      end
      OP_COMPARE_CONDITIONAL_SUBTRACT: begin
        alu_c = (s <= d);
        alu_res = alu_c ? d - s : d;
      end
      OP_DECREMENT_BRANCH_NONZERO: alu_res = d - 32'h1;
      OP_RDBYTE, OP_RDWORD, OP_HUB_READ_WORD32: alu_res = d;
      default: alu_res = d;
    endcase
    // Logic ops report parity in carry
    if (op[5:3] == 3'b011) begin
      alu_c = ^alu_res;
    end
    alu_z = (alu_res == 32'h0);
    if (op == OP_ADD_WITH_CARRY_IN || op == OP_SUBX || op == OP_ADDSX || op == OP_SUBSX || op == OP_CMPSX) begin
      alu_z = r.z & alu_z;
    end
    if (op == OP_TJZ || op == OP_TEST_BRANCH_NONZERO) begin
      alu_z = (d == 32'h0);
    end
  end

  // Flow control; test branches never write their operand
  always_comb begin
    do_jump = 1'b0;
    jump_to = r.sval[8:0];
    case (op)
      OP_JUMP_AND_LINK: do_jump = 1'b1;
      OP_DECREMENT_BRANCH_NONZERO: do_jump = (alu_res != 32'h0);
      OP_TJZ: do_jump = (r.dval == 32'h0);
      OP_TEST_BRANCH_NONZERO: do_jump = (r.dval != 32'h0);
      default: do_jump = 1'b0;
    endcase
    do_write = cond_ok && r.ir[FLD_RW] && op != OP_TJZ && op != OP_TEST_BRANCH_NONZERO;
  end

  // ****************************************
  // APB slave
  // ****************************************
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pwrite;
  assign addr_ok = (paddr == APB_CTRL) || (paddr == APB_STATUS) || (paddr == APB_LAUNCH)
                   || (paddr == APB_RAM_ADDR) || (paddr == APB_RAM_DATA);
  assign pready = 1'b1;
  // Loading code RAM while running would race the core, so it is refused
  assign pslverr = psel && penable && (!addr_ok || (pwrite && r.run && paddr == APB_RAM_DATA));
  assign prdata = r.rdata;

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    next_r = r;
    ram_we = 1'b0;
    ram_wa = dfield;
    ram_wd = alu_res;
    next_r.tick = r.tick + 32'h1;
    // Read data is captured in the setup cycle so it is a flop at the access edge
    if (apb_setup) begin
      case (paddr)
        APB_CTRL: next_r.rdata = {31'h0, r.run};
        APB_STATUS: next_r.rdata = {17'h0, r.pc, r.st, 1'b0, r.c, r.z};
        APB_LAUNCH: next_r.rdata = r.launch;
        APB_RAM_ADDR: next_r.rdata = {23'h0, r.ram_addr};
        APB_RAM_DATA: next_r.rdata = ram[r.ram_addr];
        default: next_r.rdata = 32'h0;
      endcase
    end
    if (apb_wr) begin
      case (paddr)
        APB_CTRL: next_r.run = pwdata[0];
        APB_LAUNCH: next_r.launch = pwdata;
        APB_RAM_ADDR: next_r.ram_addr = pwdata[8:0];
        default: next_r.run = r.run;
      endcase
    end
    if (apb_wr && paddr == APB_RAM_DATA && !r.run) begin
      ram_we = 1'b1;
      ram_wa = r.ram_addr;
      ram_wd = pwdata;
    end
    case (r.st)
      ST_IDLE: begin
        next_r.pc = PC_START;
        if (r.run) begin
          next_r.st = ST_FETCH;
        end
      end
      ST_FETCH: begin
        next_r.ir = ram[r.pc];
        next_r.st = r.run ? ST_SRC : ST_IDLE;
      end
      ST_SRC: begin
        // Immediate selects the zero-extended field
        next_r.sval = r.ir[FLD_IMM] ? {23'h0, sfield}
                      : core_read(sfield, r, port_in, ram[sfield]);
        next_r.st = ST_DST;
      end
      ST_DST: begin
        next_r.dval = core_read(dfield, r, port_in, ram[dfield]);
        next_r.st = ST_EXEC;
      end
      ST_EXEC: begin
        // False predicate still spends the full slot
        next_r.pc = r.pc + 9'h001;
        next_r.st = ST_FETCH;
        if (cond_ok && op[5:2] == 4'h0 && op[1:0] != 2'b11) begin
          next_r.hreq = 1'b1;
          next_r.hwe = !r.ir[FLD_RW];
          next_r.hsize = op[1:0];
          next_r.haddr = r.sval[15:0];
          next_r.hwdata = r.dval;
          next_r.st = ST_HUB;
        end else if (cond_ok) begin
          if (do_jump) begin
            next_r.pc = jump_to;
          end
          if (r.ir[FLD_CW]) begin
            next_r.c = alu_c;
          end
          if (r.ir[FLD_ZW]) begin
            next_r.z = alu_z;
          end
          // Writes to read-only specials are dropped
          if (do_write) begin
            case (dfield)
              ADR_PORT_OUT: next_r.outl = alu_res;
              ADR_PORT_DIR: next_r.dirl = alu_res;
              ADR_LAUNCH_ARG, ADR_TICK, ADR_PORT_IN: ram_we = 1'b0;
              default: ram_we = !(apb_wr && paddr == APB_RAM_DATA && !r.run);
            endcase
          end
        end
      end
      ST_HUB: begin
        if (hub_ack) begin
          next_r.hreq = 1'b0;
          next_r.st = ST_FETCH;
          if (!r.hwe) begin
            ram_wd = (r.hsize == HSZ_BYTE) ? {24'h0, hub_rdata[7:0]}
                     : (r.hsize == HSZ_WORD) ? {16'h0, hub_rdata[15:0]} : hub_rdata;
            ram_we = 1'b1;
          end
        end
      end
      default: next_r.st = ST_IDLE;
    endcase
  end

  // Register the state; code RAM has no reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  always_ff @(posedge pclk) begin
    if (ram_we) begin
      ram[ram_wa] <= ram_wd;
    end
  end

  assign hub_req = r.hreq;
  assign hub_we = r.hwe;
  assign hub_size = r.hsize;
  assign hub_addr = r.haddr;
  // Writes carry only the low unit of the register
  assign hub_wdata = (r.hsize == HSZ_BYTE) ? {24'h0, r.hwdata[7:0]}
                     : (r.hsize == HSZ_WORD) ? {16'h0, r.hwdata[15:0]} : r.hwdata;
  assign port_out = r.outl;
  assign port_dir = r.dirl;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_never_skips;
    (r.st == ST_EXEC && !cond_ok) |=> (r.pc == $past(r.pc) + 9'h001) && $stable(r.c)
      && $stable(r.z) && $stable(r.outl);
  endproperty
  a_never_skips: assert property (p_never_skips) else $error("false predicate changed state");

  property p_four_cycles;
    (r.st == ST_FETCH && r.run) |-> ##3 (r.st == ST_EXEC) ##1 (r.st != ST_EXEC);
  endproperty
  a_four_cycles: assert property (p_four_cycles) else $error("slot not four cycles");

  property p_decrement_branch_nonzero_branch;
    (r.st == ST_EXEC && cond_ok && op == OP_DECREMENT_BRANCH_NONZERO && r.dval != 32'h1)
      |=> r.pc == $past(r.sval[8:0]);
  endproperty
  a_decrement_branch_nonzero_branch: assert property (p_decrement_branch_nonzero_branch) else $error("decrement branch missed");

  property p_tj_nowrite;
    (r.st == ST_EXEC && (op == OP_TJZ || op == OP_TEST_BRANCH_NONZERO)) |-> !ram_we;
  endproperty
  a_tj_nowrite: assert property (p_tj_nowrite) else $error("test branch wrote value");

  property p_flag_hold;
    (r.st == ST_EXEC && !r.ir[FLD_CW]) |=> $stable(r.c);
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("carry changed without update");

  property p_hub_hold;
    (hub_req && !hub_ack) |=> hub_req && $stable(hub_addr) && $stable(hub_we);
  endproperty
  a_hub_hold: assert property (p_hub_hold) else $error("hub request dropped early");

  property p_neg;
    (r.st == ST_EXEC && op == OP_NEG) |-> alu_res + r.sval == 32'h0;
  endproperty
  a_neg: assert property (p_neg) else $error("negation wrong");

  property p_compare_conditional_subtract;
    (r.st == ST_EXEC && op == OP_COMPARE_CONDITIONAL_SUBTRACT && r.sval > r.dval) |-> alu_res == r.dval && !alu_c;
  endproperty
  a_compare_conditional_subtract: assert property (p_compare_conditional_subtract) else $error("conditional subtract wrong");

  property p_test_nowrite;
    (r.st == ST_EXEC && op == OP_AND && !r.ir[FLD_RW]) |-> !ram_we;
  endproperty
  a_test_nowrite: assert property (p_test_nowrite) else $error("test wrote result");

endmodule
`default_nettype wire

/* bench/iex_hub_model.sv */
// Behavioural shared memory arbiter answering the core's hub port
`timescale 1ns/10ps
`default_nettype none
module iex_hub_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic hub_req,
  input wire logic hub_we,
  input wire logic [1:0] hub_size,
  input wire logic [15:0] hub_addr,
  input wire logic [31:0] hub_wdata,
  output logic hub_ack,
  output logic [31:0] hub_rdata
);
  logic [7:0] mem [0:255];
  int wait_n;
  logic slow;
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
  end
  // Alternate prompt and slow answers; read data is scrambled outside the ack cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hub_ack <= 1'b0;
      hub_rdata <= 32'h0;
      wait_n <= 0;
      slow <= 1'b0;
    end else begin
      hub_ack <= 1'b0;
      hub_rdata <= ~hub_rdata;
      if (hub_req && !hub_ack) begin
        if (wait_n < (slow ? 3 : 0)) begin
          wait_n <= wait_n + 1;
        end else begin
          wait_n <= 0;
          slow <= ~slow;
          hub_ack <= 1'b1;
          // Whole long is returned; the core must keep only the addressed unit
          hub_rdata <= {mem[8'(hub_addr + 3)], mem[8'(hub_addr + 2)],
                        mem[8'(hub_addr + 1)], mem[hub_addr[7:0]]};
          for (int k = 0; k < 4; k++) begin
            if (hub_we && k < (1 << hub_size)) mem[8'(hub_addr + k)] <= hub_wdata[8*k +: 8];
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

/* bench/iex_core_tb_top.sv */
// Self-checking testbench of the execution core
`timescale 1ns/10ps
`default_nettype none
module iex_core_tb_top
  import iex_pkg::*;
;
  localparam logic [31:0] D0 = 32'hF000_1234;
  localparam logic [31:0] S0 = 32'h0000_0025;
  localparam logic [31:0] S1 = 32'hFFFF_FF9B;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hub_req, hub_we, hub_ack, err;
  logic [11:0] paddr;
  logic [1:0] hub_size;
  logic [15:0] hub_addr;
  logic [31:0] pwdata, prdata, hub_wdata, hub_rdata, port_in, port_out, port_dir, rd;
  int n_errors, compares;
  iex_core dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .hub_req, .hub_we, .hub_size, .hub_addr, .hub_wdata, .hub_ack,
    .hub_rdata, .port_in, .port_out, .port_dir);
  iex_hub_model hub_u (.pclk, .presetn, .hub_req, .hub_we, .hub_size, .hub_addr,
    .hub_wdata, .hub_ack, .hub_rdata);
  always #5 pclk = ~pclk;
  // ****************
  // Helpers
  // ****************
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Request is held until pready is seen high at an edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task ram(input logic [8:0] a, input logic [31:0] w);
    apb(1'b1, APB_RAM_ADDR, {23'h0, a});
    apb(1'b1, APB_RAM_DATA, w);
  endtask
  // Bounded status poll; running out of tries shows as a mismatch
  task poll(input logic [31:0] mask, input logic [31:0] val);
    for (int k = 0; k < 300; k++) begin
      apb(1'b0, APB_STATUS, 32'h0);
      if ((rd & mask) === val) break;
    end
    chk("status", val, rd & mask);
  endtask
  function automatic logic [31:0] ins(logic [5:0] op, logic [3:0] e, logic [3:0] cc,
    logic [8:0] d, logic [8:0] s);
    return {op, e, cc, d, s};
  endfunction
  function automatic logic [31:0] mv(logic [8:0] d, logic [8:0] s);
    return ins(OP_MOV, 4'b0010, 4'hF, d, s);
  endfunction
  // Subtracting f from zero leaves C = f and Z = !f
  function automatic logic [31:0] pre(logic f);
    return ins(OP_SUB, 4'b1101, 4'hF, 9'h102, {8'h0, f});
  endfunction
  // Reference result; v is the selected flag condition of the four-way variants
  function automatic logic [31:0] alu(logic [5:0] op, logic [31:0] d, logic [31:0] s, logic c);
    logic [31:0] a;
    logic v;
    int n;
    n = s[4:0];
    a = s[31] ? -s : s;
    v = c ^ op[0] ^ op[1];
    case (op)
      OP_ROR: return 32'({d, d} >> n);
      OP_ROL: return 32'(({d, d} << n) >> 32);
      OP_SHR: return d >> n;
      OP_SHL: return d << n;
      OP_RCR: return (d >> n) | ({32{c}} & ~(32'hFFFF_FFFF >> n));
      OP_RCL: return (d << n) | ({32{c}} & ~(32'hFFFF_FFFF << n));
      OP_SAR: return $signed(d) >>> n;
      OP_REV: return 32'({<<{d}}) >> n;
      OP_SIGNED_FLOOR: return $signed(d) < $signed(s) ? s : d;
      OP_SIGNED_CEILING: return $signed(d) > $signed(s) ? s : d;
      OP_MIN: return d < s ? s : d;
      OP_MAX: return d > s ? s : d;
      OP_SET_SOURCE_FIELD: return {d[31:9], s[8:0]};
      OP_SET_DEST_FIELD: return {d[31:18], s[8:0], d[8:0]};
      OP_SET_OPCODE_FIELD: return {s[8:0], d[22:0]};
      OP_AND: return d & s;
      OP_ANDN: return d & ~s;
      OP_OR: return d | s;
      OP_XOR: return d ^ s;
      OP_CARRY_BIT_MERGE, OP_MUXNC, OP_MUXZ, OP_MUXNZ: return (d & ~s) | (s & {32{v}});
      OP_CARRY_SIGNED_SUM, OP_SUMNC, OP_SUMZ, OP_SUMNZ: return v ? d - s : d + s;
      OP_CARRY_CONDITIONAL_NEGATE, OP_NEGNC, OP_NEGZ, OP_NEGNZ: return v ? -s : s;
      OP_ADD, OP_ADDS: return d + s;
      OP_SUB, OP_SUBS, OP_CMPS: return d - s;
      OP_ADDABS: return d + a;
      OP_SUBABS: return d - a;
      OP_MOV: return s;
      OP_NEG: return -s;
      OP_ABS: return a;
      OP_NEGATED_MAGNITUDE: return -a;
      OP_ADD_WITH_CARRY_IN, OP_ADDSX: return d + s + c;
      OP_SUBX, OP_SUBSX, OP_CMPSX: return d - s - c;
      OP_COMPARE_CONDITIONAL_SUBTRACT: return s <= d ? d - s : d;
      default: return d;
    endcase
  endfunction
  // Load two instructions, copy 0x100 to the port, park, then stop the core
  task run_prog(input logic [31:0] i0, input logic [31:0] i1, input logic [31:0] d,
    input logic [31:0] s);
    ram(9'h0, i0);
    ram(9'h1, i1);
    ram(9'h2, mv(9'h1F4, 9'h100));
    ram(9'h3, ins(OP_JUMP_AND_LINK, 4'b0001, 4'hF, 9'h0, 9'h003));
    ram(9'h100, d);
    ram(9'h101, s);
    ram(9'h102, 32'h0);
    apb(1'b1, APB_CTRL, 32'h1);
    apb(1'b1, APB_RAM_DATA, 32'h0);
    chk("refused", 32'h1, {31'h0, err});
    poll(32'h7FC0, 32'h00C0);
    apb(1'b1, APB_CTRL, 32'h0);
    poll(32'h38, 32'h0);
  endtask
  // ****************
  // Scenarios
  // ****************
  task t_reset();
    chk("port_out", 32'h0, port_out);
    chk("port_dir", 32'h0, port_dir);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    apb(1'b1, APB_LAUNCH, 32'h2468_ACE0);
    $display("reset test done");
  endtask
  task t_alu();
    logic [31:0] sv;
    for (int i = 8; i < 57; i++) begin
      if (i inside {23}) continue;
      for (int j = 0; j < 4; j++) begin
        sv = j[1] ? S1 : S0;
        run_prog(pre(j[0]), ins(6'(i), 4'b0010, 4'hF, 9'h100, 9'h101), D0, sv);
        chk("alu", alu(6'(i), D0, sv, j[0]), port_out);
      end
    end
    run_prog(pre(1'b0), ins(OP_AND, 4'b1000, 4'hF, 9'h100, 9'h101), D0, S0);
    chk("test_op", D0, port_out);
    $display("alu test done");
  endtask
  task t_cond();
    for (int i = 0; i < 32; i++) begin
      run_prog(pre(i[0]), ins(OP_MOV, 4'b0011, i[4:1], 9'h100, 9'h0AA), D0, S0);
      chk("cond", i[{i[0], ~i[0]} + 1] ? 32'h0AA : D0, port_out);
      apb(1'b0, APB_STATUS, 32'h0);
      chk("flags", {30'h0, i[0], ~i[0]}, {30'h0, rd[1:0]});
    end
    $display("cond test done");
  endtask
  task t_flow();
    logic [31:0] sv;
    run_prog(ins(OP_ADD, 4'b0011, 4'hF, 9'h100, 9'h001),
      ins(OP_DECREMENT_BRANCH_NONZERO, 4'b0011, 4'hF, 9'h101, 9'h000), D0, 32'h3);
    chk("decrement_branch_nonzero", D0 + 32'h3, port_out);
    for (int i = 0; i < 4; i++) begin
      sv = i[1] ? 32'h3 : 32'h0;
      run_prog(ins(i[0] ? OP_TJZ : OP_TEST_BRANCH_NONZERO, 4'b0001, 4'hF, 9'h101, 9'h002),
        ins(OP_ADD, 4'b0011, 4'hF, 9'h100, 9'h001), D0, sv);
      chk("tj", (i[0] == !i[1]) ? D0 : D0 + 32'h1, port_out);
    end
    run_prog(ins(OP_JUMP_AND_LINK, 4'b0011, 4'hF, 9'h100, 9'h002),
      ins(OP_ADD, 4'b0011, 4'hF, 9'h100, 9'h001), D0, S0);
    chk("call", {D0[31:9], 9'h001}, port_out);
    $display("flow test done");
  endtask
  task t_hub();
    run_prog(ins(OP_HUB_READ_WORD32, 4'b0001, 4'hF, 9'h100, 9'h040),
      ins(OP_RDWORD, 4'b0011, 4'hF, 9'h100, 9'h040), D0, S0);
    chk("hub_word", {16'h0, D0[15:0]}, port_out);
    run_prog(ins(OP_RDBYTE, 4'b0001, 4'hF, 9'h100, 9'h044),
      ins(OP_HUB_READ_WORD32, 4'b0011, 4'hF, 9'h100, 9'h044), D0, S0);
    chk("hub_byte", {24'h0, D0[7:0]}, port_out);
    $display("hub test done");
  endtask
  task t_regs();
    run_prog(ins(OP_MOV, 4'b0011, 4'hF, 9'h1F0, 9'h005), mv(9'h100, 9'h1F0), D0, S0);
    chk("launch", 32'h2468_ACE0, port_out);
    run_prog(mv(9'h100, 9'h1F2), mv(9'h100, 9'h1F2), D0, S0);
    chk("port_in", port_in, port_out);
    run_prog(mv(9'h1F6, 9'h101), mv(9'h1F6, 9'h101), D0, S1);
    chk("port_dir", S1, port_dir);
    $display("register test done");
  endtask
  task print_verdict();
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    port_in = 32'h5A3C_96E1;
    n_errors = 0;
    compares = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_alu();
    t_cond();
    t_flow();
    t_hub();
    t_regs();
    print_verdict();
  end
  // Watchdog: the full run needs well under this many cycles
  initial begin
    repeat (60000) @(posedge pclk);
    n_errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
